// ---- src/adcsq_defines.vh ----
// register offsets, field positions, reset values and counts of the converter sequencer
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define ADCSQ_OFS_PAIR_CFG 8'hBA
`define ADCSQ_OFS_CHAN_SEL 8'hBB
`define ADCSQ_OFS_CONV_CFG 8'hBC
`define ADCSQ_OFS_RES_LOW 8'hBE
`define ADCSQ_OFS_RES_HIGH 8'hBF
`define ADCSQ_OFS_UPPER_LOW 8'hC4
`define ADCSQ_OFS_UPPER_HIGH 8'hC5
`define ADCSQ_OFS_LOWER_LOW 8'hC6
`define ADCSQ_OFS_LOWER_HIGH 8'hC7
`define ADCSQ_OFS_REF_CTRL 8'hD1
`define ADCSQ_OFS_CONV_CTRL 8'hE8
// ****************************************
// control register bit positions
// ****************************************
`define ADCSQ_CTL_ENABLE 7
`define ADCSQ_CTL_TRACK_MODE 6
`define ADCSQ_CTL_DONE 5
`define ADCSQ_CTL_BUSY 4
`define ADCSQ_CTL_START_HI 3
`define ADCSQ_CTL_START_LO 2
`define ADCSQ_CTL_WINDOW 1
`define ADCSQ_CTL_LEFT_JUST 0
// ****************************************
// other field positions
// ****************************************
`define ADCSQ_CFG_SCALE_HI 4
`define ADCSQ_CFG_SCALE_LO 3
`define ADCSQ_CFG_GAIN_HI 2
`define ADCSQ_CFG_GAIN_LO 0
`define ADCSQ_REF_BIAS 1
// ****************************************
// reset values
// ****************************************
`define ADCSQ_RST_PAIR_CFG 4'h0
`define ADCSQ_RST_CHAN_SEL 4'h0
`define ADCSQ_RST_CONV_CFG 8'h00
`define ADCSQ_RST_CONV_CTRL 8'h00
`define ADCSQ_RST_REF_CTRL 8'h00
`define ADCSQ_RST_UPPER 16'hFFFF
`define ADCSQ_RST_LOWER 16'h0000
// ****************************************
// modes, codes and counts
// ****************************************
`define ADCSQ_START_SW 2'h0
`define ADCSQ_START_TMR3 2'h1
`define ADCSQ_START_PIN 2'h2
`define ADCSQ_START_TMR2 2'h3
`define ADCSQ_TEMP_CHANNEL 4'h8
`define ADCSQ_TRACK_CLOCKS 2'h3
`endif

// ---- src/adcsq_window.v ----
// window comparator on the 16-bit result word
`timescale 1ns/10ps
`default_nettype none
module adcsq_window (
  input wire [15:0] data_i,
  input wire signed_i,
  input wire [15:0] upper_i,
  input wire [15:0] lower_i,
  output wire match_o
);
  // sign bit flipped turns signed order into unsigned order, one comparator serves both
  wire [15:0] d = {data_i[15] ^ signed_i, data_i[14:0]};
  wire [15:0] g = {upper_i[15] ^ signed_i, upper_i[14:0]};
  wire [15:0] l = {lower_i[15] ^ signed_i, lower_i[14:0]};
  wire below = d < l;
  wire above = d > g;
  // inside window when lower-than word exceeds greater-than word, else outside
  assign match_o = (l > g) ? (below & above) : (below | above);
endmodule // adcsq_window
`default_nettype wire

// ---- src/adcsq_sar.v ----
// successive-approximation sequencer: track phase, ten bit trials, done pulse
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_defines.vh"
module adcsq_sar (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire enable_i,
  input wire tick_i,
  input wire start_i,
  input wire track_phase_i,
  input wire cmp_i,
  output reg busy_o,
  output reg done_o,
  output reg track_o,
  output reg [9:0] code_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_TRACK = 2'd1;
  localparam ST_CONV = 2'd2;
  reg [1:0] state;
  reg [1:0] track_cnt;
  reg [9:0] mask;
  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      track_cnt <= 2'h0;
      mask <= 10'h000;
      code_o <= 10'h000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      track_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (!enable_i) begin
        // shutdown aborts any conversion without a done pulse
        state <= ST_IDLE;
        busy_o <= 1'b0;
        track_o <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_i) begin
              busy_o <= 1'b1;
              track_cnt <= 2'h0;
              if (track_phase_i) begin
                state <= ST_TRACK;
                track_o <= 1'b1;
              end else begin
                state <= ST_CONV;
                mask <= 10'h200;
                code_o <= 10'h200;
              end
            end
          end
          ST_TRACK: begin
            if (tick_i) begin
              track_cnt <= track_cnt + 2'h1;
              if (track_cnt == `ADCSQ_TRACK_CLOCKS - 2'h1) begin
                state <= ST_CONV;
                track_o <= 1'b0;
                mask <= 10'h200;
                code_o <= 10'h200;
              end
            end
          end
          ST_CONV: begin
            if (tick_i) begin
              // drop the trial bit when the input is below the trial level
              code_o <= (cmp_i ? code_o : (code_o & ~mask)) | (mask >> 1);
              mask <= mask >> 1;
              if (mask[0]) begin
                state <= ST_IDLE;
                busy_o <= 1'b0;
                done_o <= 1'b1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // adcsq_sar
`default_nettype wire

// ---- src/adcsq_top.v ----
// converter sequencer top: registers, triggers, prescaler, result and flags
// ****************************************
// Overview of operation
// - converter, track-and-hold and gain stage run only while enable bit is 1
// - nine mux channels: eight external plus temperature sensor
// - input pairs selectable differential or single-ended, all single-ended after reset
// - gain field selects 0.5 to 16, unity after reset
// - programmed gain also applies to the temperature channel
// - conversion clock is system clock divided by 2, 4, 8 or 16
// - start-mode field picks software, timer 3, pin edge or timer 2 trigger
// - busy reads 1 through a conversion and 0 once finished
// - busy falling at a completed conversion, not on an abort, sets the done flag and the interrupt request
// - each conversion yields a 10-bit successive approximation result
// - result placed left or right justified in the result byte pair
// - with track mode 0 input tracks except during conversion
// - track mode 1 with software or timer start: 3 conversion clocks of tracking
// - track mode 1 with pin start: track only while pin low
// - after each conversion compare against limits and set window flag
// - window flag for inside or outside limits, by limit ordering
// - each limit word is high byte concatenated with low byte
// - lower limit above upper: flag only when strictly between them
// - differential results and comparisons are signed two's complement
// ****************************************
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_defines.vh"
module adcsq_top (
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  input wire CE_I,
  input wire [7:0] SFR_ADDR_I,
  input wire [7:0] SFR_WDATA_I,
  input wire SFR_WE_I,
  output reg [7:0] SFR_RDATA_O,
  input wire TMR2_OVF_I,
  input wire TMR3_OVF_I,
  input wire EXT_CONVERT_START_I,
  input wire CMP_I,
  output wire CONV_ENABLE_O,
  output wire BIAS_ENABLE_O,
  output wire TRACK_O,
  output wire [9:0] DAC_CODE_O,
  output wire [3:0] MUX_SEL_O,
  output wire [3:0] PAIR_DIFF_O,
  output wire [2:0] GAIN_SEL_O,
  output wire DONE_IRQ_O,
  output wire WINDOW_IRQ_O
);
  // ****************************************
  // register storage
  // ****************************************
  reg [3:0] pair_config_reg;
  reg [3:0] channel_select_reg;
  reg [7:0] converter_config_reg;
  reg [7:0] reference_control_reg;
  reg converter_enable;
  reg track_mode_select;
  reg conversion_done_flag;
  reg window_match_flag;
  reg [1:0] start_mode;
  reg left_justify_select;
  reg [15:0] upper_limit;
  reg [15:0] lower_limit;
  reg [15:0] result_word;
  reg [2:0] pin_sync;
  reg pin_level;
  reg [3:0] pre_cnt;
  reg conv_diff;
  wire conversion_busy;
  wire sar_done;
  wire sar_track;
  wire [9:0] sar_code;
  wire win_match;
  wire [15:0] next_result;
  wire [1:0] scale;
  wire [3:0] pre_max;
  wire tick;
  wire wr_ctrl;
  wire sw_start;
  wire pin_rise;
  wire start;
  wire track_phase;
  wire chan_diff;
  wire [3:0] chan;

  assign wr_ctrl = SFR_WE_I & (SFR_ADDR_I == `ADCSQ_OFS_CONV_CTRL);
  assign scale = converter_config_reg[`ADCSQ_CFG_SCALE_HI:`ADCSQ_CFG_SCALE_LO];
  assign chan = channel_select_reg;

  // ****************************************
  // external start pin synchroniser
  // ****************************************
  // three stages; a change counts once stages two and three agree
  always @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
    end else if (CE_I) begin
      pin_sync <= {pin_sync[1:0], EXT_CONVERT_START_I};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
    end
  end

  // rising edge of the filtered pin level
  assign pin_rise = (pin_sync[1] == pin_sync[2]) & pin_sync[2] & ~pin_level;

  // ****************************************
  // trigger selection
  // ****************************************
  // software start is a write of 1 to busy while idle in software mode
  assign sw_start = wr_ctrl & SFR_WDATA_I[`ADCSQ_CTL_BUSY] & ~conversion_busy;
  assign start = converter_enable & ~conversion_busy &
                 ((start_mode == `ADCSQ_START_SW) ? sw_start :
                  (start_mode == `ADCSQ_START_TMR3) ? TMR3_OVF_I :
                  (start_mode == `ADCSQ_START_PIN) ? pin_rise :
                  TMR2_OVF_I);
  // pin mode tracks while low instead of a counted track phase
  assign track_phase = track_mode_select & (start_mode != `ADCSQ_START_PIN);

  // ****************************************
  // conversion clock prescaler
  // ****************************************
  // divide by 2 << scale; counter runs only while enabled to save power
  assign pre_max = (scale == 2'h0) ? 4'h1 :
                   (scale == 2'h1) ? 4'h3 :
                   (scale == 2'h2) ? 4'h7 : 4'hF;
  // at or above, so a smaller divide written mid-count cannot stall for a wrap
  assign tick = converter_enable & (pre_cnt >= pre_max);
  always @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      pre_cnt <= 4'h0;
    end else if (CE_I) begin
      if (!converter_enable || tick) begin
        pre_cnt <= 4'h0;
      end else begin
        pre_cnt <= pre_cnt + 4'h1;
      end
    end
  end

  // ****************************************
  // successive approximation engine
  // ****************************************
  adcsq_sar u_sar (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .ce_i(CE_I),
    .enable_i(converter_enable),
    .tick_i(tick),
    .start_i(start),
    .track_phase_i(track_phase),
    .cmp_i(CMP_I),
    .busy_o(conversion_busy),
    .done_o(sar_done),
    .track_o(sar_track),
    .code_o(sar_code)
  );

  // ****************************************
  // channel mode and result formatting
  // ****************************************
  // channel 8 and above is the temperature sensor, never differential
  assign chan_diff = ~chan[3] & pair_config_reg[chan[2:1]];

  // latch mode at start so a mid-conversion change cannot corrupt the format
  always @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      conv_diff <= 1'b0;
    end else if (CE_I && start) begin
      conv_diff <= chan_diff;
    end
  end

  // differential: offset code to two's complement by flipping the msb
  wire [9:0] signed_code = {sar_code[9] ^ conv_diff, sar_code[8:0]};
  assign next_result = left_justify_select ? {signed_code, 6'h00} :
                       {{6{conv_diff & signed_code[9]}}, signed_code};

  adcsq_window u_window (
    .data_i(next_result),
    .signed_i(conv_diff),
    .upper_i(upper_limit),
    .lower_i(lower_limit),
    .match_o(win_match)
  );

  // ****************************************
  // register writes and flags
  // ****************************************
  // flags: hardware set wins over a software clear in the same cycle
  always @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      pair_config_reg <= `ADCSQ_RST_PAIR_CFG;
      channel_select_reg <= `ADCSQ_RST_CHAN_SEL;
      converter_config_reg <= `ADCSQ_RST_CONV_CFG;
      reference_control_reg <= `ADCSQ_RST_REF_CTRL;
      converter_enable <= 1'b0;
      track_mode_select <= 1'b0;
      conversion_done_flag <= 1'b0;
      window_match_flag <= 1'b0;
      start_mode <= `ADCSQ_START_SW;
      left_justify_select <= 1'b0;
      upper_limit <= `ADCSQ_RST_UPPER;
      lower_limit <= `ADCSQ_RST_LOWER;
      result_word <= 16'h0000;
    end else if (CE_I) begin
      if (SFR_WE_I) begin
        case (SFR_ADDR_I)
          `ADCSQ_OFS_PAIR_CFG: pair_config_reg <= SFR_WDATA_I[3:0];
          `ADCSQ_OFS_CHAN_SEL: channel_select_reg <= SFR_WDATA_I[3:0];
          `ADCSQ_OFS_CONV_CFG: converter_config_reg <= SFR_WDATA_I;
          `ADCSQ_OFS_REF_CTRL: reference_control_reg <= SFR_WDATA_I;
          `ADCSQ_OFS_UPPER_LOW: upper_limit[7:0] <= SFR_WDATA_I;
          `ADCSQ_OFS_UPPER_HIGH: upper_limit[15:8] <= SFR_WDATA_I;
          `ADCSQ_OFS_LOWER_LOW: lower_limit[7:0] <= SFR_WDATA_I;
          `ADCSQ_OFS_LOWER_HIGH: lower_limit[15:8] <= SFR_WDATA_I;
          `ADCSQ_OFS_CONV_CTRL: begin
            converter_enable <= SFR_WDATA_I[`ADCSQ_CTL_ENABLE];
            track_mode_select <= SFR_WDATA_I[`ADCSQ_CTL_TRACK_MODE];
            start_mode <= SFR_WDATA_I[`ADCSQ_CTL_START_HI:`ADCSQ_CTL_START_LO];
            left_justify_select <= SFR_WDATA_I[`ADCSQ_CTL_LEFT_JUST];
            // only a written 0 clears; a written 1 leaves the flag alone
            if (!SFR_WDATA_I[`ADCSQ_CTL_DONE]) begin
              conversion_done_flag <= 1'b0;
            end
            if (!SFR_WDATA_I[`ADCSQ_CTL_WINDOW]) begin
              window_match_flag <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      if (sar_done) begin
        result_word <= next_result;
        conversion_done_flag <= 1'b1;
        if (win_match) begin
          window_match_flag <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // one cycle read latency; unmapped offsets read zero
  always @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      SFR_RDATA_O <= 8'h00;
    end else if (CE_I) begin
      case (SFR_ADDR_I)
        `ADCSQ_OFS_PAIR_CFG: SFR_RDATA_O <= {4'h0, pair_config_reg};
        `ADCSQ_OFS_CHAN_SEL: SFR_RDATA_O <= {4'h0, channel_select_reg};
        `ADCSQ_OFS_CONV_CFG: SFR_RDATA_O <= converter_config_reg;
        `ADCSQ_OFS_REF_CTRL: SFR_RDATA_O <= reference_control_reg;
        `ADCSQ_OFS_RES_LOW: SFR_RDATA_O <= result_word[7:0];
        `ADCSQ_OFS_RES_HIGH: SFR_RDATA_O <= result_word[15:8];
        `ADCSQ_OFS_UPPER_LOW: SFR_RDATA_O <= upper_limit[7:0];
        `ADCSQ_OFS_UPPER_HIGH: SFR_RDATA_O <= upper_limit[15:8];
        `ADCSQ_OFS_LOWER_LOW: SFR_RDATA_O <= lower_limit[7:0];
        `ADCSQ_OFS_LOWER_HIGH: SFR_RDATA_O <= lower_limit[15:8];
        `ADCSQ_OFS_CONV_CTRL: SFR_RDATA_O <= {converter_enable, track_mode_select,
                                              conversion_done_flag, conversion_busy,
                                              start_mode, window_match_flag,
                                              left_justify_select};
        default: SFR_RDATA_O <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // analog front-end controls
  // ****************************************
  // the analog chain apart from the bias powers down with the enable bit
  assign CONV_ENABLE_O = converter_enable;
  // bias is software's duty; the block only forwards the bit
  assign BIAS_ENABLE_O = reference_control_reg[`ADCSQ_REF_BIAS];
  assign MUX_SEL_O = channel_select_reg;
  assign PAIR_DIFF_O = pair_config_reg;
  // gain drives the stage for every channel, the temperature sensor included
  assign GAIN_SEL_O = converter_config_reg[`ADCSQ_CFG_GAIN_HI:`ADCSQ_CFG_GAIN_LO];
  assign DAC_CODE_O = sar_code;
  // tracking: continuous unless converting, counted phase, or pin low
  assign TRACK_O = converter_enable &
                   (!track_mode_select ? ~conversion_busy :
                    (start_mode == `ADCSQ_START_PIN) ? ~pin_level :
                    sar_track);
  assign DONE_IRQ_O = conversion_done_flag;
  assign WINDOW_IRQ_O = window_match_flag;
endmodule // adcsq_top
`default_nettype wire

// ---- testbench/adcsq_monitor.sv ----
// assertion checker watching the converter sequencer top ports
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_defines.vh"
module adcsq_monitor (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_WE_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic TMR2_OVF_I,
  input wire logic TMR3_OVF_I,
  input wire logic EXT_CONVERT_START_I,
  input wire logic CMP_I,
  input wire logic CONV_ENABLE_O,
  input wire logic BIAS_ENABLE_O,
  input wire logic TRACK_O,
  input wire logic [9:0] DAC_CODE_O,
  input wire logic [3:0] MUX_SEL_O,
  input wire logic [3:0] PAIR_DIFF_O,
  input wire logic [2:0] GAIN_SEL_O,
  input wire logic DONE_IRQ_O,
  input wire logic WINDOW_IRQ_O
);
  // ****
  // write decode
  // ****
  // a write only lands with the clock enable high
  wire logic wr = CE_I && SFR_WE_I;
  wire logic wr_ctl = wr && SFR_ADDR_I == `ADCSQ_OFS_CONV_CTRL;
  wire logic rd_chan = CE_I && !SFR_WE_I && SFR_ADDR_I == `ADCSQ_OFS_CHAN_SEL;

  default clocking mon_cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  // ****
  // assertions
  // ****
  // reset must clear outputs even though the default disable would hide it
  a_reset_clears: assert property (disable iff (1'b0)
    (!RESET_N_I && CE_I) |=> SFR_RDATA_O == 8'h00 && GAIN_SEL_O == 3'h0 && PAIR_DIFF_O == 4'h0)
    else $error("outputs not cleared by reset");
  a_enable_write: assert property (
    wr_ctl |=> CONV_ENABLE_O == $past(SFR_WDATA_I[`ADCSQ_CTL_ENABLE]))
    else $error("enable bit did not follow write");
  a_track_off: assert property (!CONV_ENABLE_O |-> !TRACK_O)
    else $error("tracking while disabled");
  a_gain_write: assert property (
    wr && SFR_ADDR_I == `ADCSQ_OFS_CONV_CFG |=> GAIN_SEL_O == $past(SFR_WDATA_I[2:0]))
    else $error("gain field did not follow write");
  a_pair_write: assert property (
    wr && SFR_ADDR_I == `ADCSQ_OFS_PAIR_CFG |=> PAIR_DIFF_O == $past(SFR_WDATA_I[3:0]))
    else $error("pair config did not follow write");
  a_bias_write: assert property (
    wr && SFR_ADDR_I == `ADCSQ_OFS_REF_CTRL |=> BIAS_ENABLE_O == $past(SFR_WDATA_I[1]))
    else $error("bias bit did not follow write");
  a_chan_read: assert property (
    rd_chan |=> SFR_RDATA_O == {4'h0, $past(MUX_SEL_O)})
    else $error("channel read back wrong");
  a_done_holds: assert property (
    DONE_IRQ_O && !(wr_ctl && !SFR_WDATA_I[`ADCSQ_CTL_DONE]) |=> DONE_IRQ_O)
    else $error("done flag dropped without clear");
  a_window_holds: assert property (
    WINDOW_IRQ_O && !(wr_ctl && !SFR_WDATA_I[`ADCSQ_CTL_WINDOW]) |=> WINDOW_IRQ_O)
    else $error("window flag dropped without clear");
  a_done_enabled: assert property ($rose(DONE_IRQ_O) |-> $past(CONV_ENABLE_O))
    else $error("done set while disabled");

  // main scenarios reached
  c_done: cover property ($rose(DONE_IRQ_O));
  c_window: cover property ($rose(WINDOW_IRQ_O));
  c_track_end: cover property ($fell(TRACK_O) && CONV_ENABLE_O);
endmodule // adcsq_monitor

bind adcsq_top adcsq_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_WE_I(SFR_WE_I),
  .SFR_RDATA_O(SFR_RDATA_O), .TMR2_OVF_I(TMR2_OVF_I), .TMR3_OVF_I(TMR3_OVF_I),
  .EXT_CONVERT_START_I(EXT_CONVERT_START_I), .CMP_I(CMP_I), .CONV_ENABLE_O(CONV_ENABLE_O),
  .BIAS_ENABLE_O(BIAS_ENABLE_O), .TRACK_O(TRACK_O), .DAC_CODE_O(DAC_CODE_O),
  .MUX_SEL_O(MUX_SEL_O), .PAIR_DIFF_O(PAIR_DIFF_O), .GAIN_SEL_O(GAIN_SEL_O),
  .DONE_IRQ_O(DONE_IRQ_O), .WINDOW_IRQ_O(WINDOW_IRQ_O));
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_defines.vh"
module tb;
  logic clk, rst_n, ce, we, t2, t3, pin, cmp;
  logic [7:0] addr, wdata, ctl, rv;
  logic [9:0] target, v;
  wire logic [7:0] rdata;
  wire logic en_o, bias_o, track_o, done_o, win_o;
  wire logic [9:0] dac;
  wire logic [3:0] mux, pair;
  wire logic [2:0] gain;
  int fail_count, checks, cyc;
  logic [7:0] ofs [12] = '{8'hBA, 8'hBB, 8'hBC, 8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7,
    8'hD1, 8'hE8, 8'h80};
  logic [7:0] rst [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [15:0] lo_t [7] = '{16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100};
  logic [15:0] up_t [7] = '{16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0200, 16'hFFFF, 16'hFFFF};
  logic [9:0] tg_t [7] = '{10'h180, 10'h100, 10'h080, 10'h200, 10'h201, 10'h1FF, 10'h200};
  logic [6:0] wx = 7'b1010101;

  adcsq_top dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .SFR_ADDR_I(addr),
    .SFR_WDATA_I(wdata), .SFR_WE_I(we), .SFR_RDATA_O(rdata), .TMR2_OVF_I(t2), .TMR3_OVF_I(t3),
    .EXT_CONVERT_START_I(pin), .CMP_I(cmp), .CONV_ENABLE_O(en_o), .BIAS_ENABLE_O(bias_o),
    .TRACK_O(track_o), .DAC_CODE_O(dac), .MUX_SEL_O(mux), .PAIR_DIFF_O(pair),
    .GAIN_SEL_O(gain), .DONE_IRQ_O(done_o), .WINDOW_IRQ_O(win_o));

  // ****
  // clock, analog input and cycle ceiling
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // input level is target: comparator says input at or above trial code
  always @(negedge clk) cmp <= (dac <= target);
  // ceiling far above the roughly one thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  // ****
  // tasks
  // ****
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe, dropped at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask
  // trigger m, divide d, x extra track ticks; times the conversion
  task automatic conv(input logic [1:0] m, input logic [9:0] t, input int d, input int x);
    int n;
    target = t;
    @(negedge clk);
    case (m)
      2'h0: begin
        addr = 8'hE8;
        wdata = ctl | 8'h10;
        we = 1'b1;
      end
      2'h1: t3 = 1'b1;
      2'h2: pin = 1'b1;
      default: t2 = 1'b1;
    endcase
    @(negedge clk);
    {we, t3, t2} = 3'h0;
    n = 1;
    while (done_o !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
      if (x > 0 && n == 2) chk("track phase", 16'(track_o), 16'h1);
      if (n == (x + 2) * d + 4) chk("track in conversion", 16'(track_o), 16'h0);
    end
    chk("conversion time", 16'(n >= (9 + x) * d + 3 && n <= (10 + x) * d + 6), 16'h1);
  endtask
  task automatic res(input logic [15:0] e);
    logic [7:0] hi, lo, c;
    rd(8'hBF, hi);
    rd(8'hBE, lo);
    rd(8'hE8, c);
    chk("result", {hi, lo}, e);
    chk("busy and done", 16'(c[5:4]), 16'h2);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    {rst_n, we, t2, t3, pin} = 5'h0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    target = 10'h000;
    ctl = 8'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // reset values and an unmapped place
    foreach (ofs[i]) begin
      rd(ofs[i], rv);
      chk("reset value", 16'(rv), 16'(rst[i]));
    end
    wr(8'hBA, 8'hFF);
    rd(8'hBA, rv);
    chk("pair cfg", 16'(rv), 16'h000F);
    wr(8'hBE, 8'h55);
    rd(8'hBE, rv);
    chk("result read-only", 16'(rv), 16'h0000);
    wr(8'hBA, 8'h00);
    for (int g = 0; g < 8; g++) begin
      wr(8'hBC, 8'(g));
      chk("gain", 16'(gain), 16'(g));
    end
    wr(8'hBB, 8'h08);
    chk("temp channel", 16'(mux), 16'h0008);
    chk("gain kept", 16'(gain), 16'h0007);
    wr(8'hBB, 8'h00);
    // a write with the clock enable low must not land
    ce = 1'b0;
    wr(8'hBB, 8'h05);
    ce = 1'b1;
    chk("frozen write", 16'(mux), 16'h0000);
    // a start while disabled is ignored
    wr(8'hE8, 8'h10);
    rd(8'hE8, rv);
    chk("start while off", 16'(rv), 16'h0000);
    wr(8'hD1, 8'h02);
    chk("bias", 16'(bias_o), 16'h1);
    ctl = 8'h80;
    wr(8'hE8, ctl);
    chk("idle tracking", 16'(track_o), 16'h1);
    for (int s = 0; s < 4; s++) begin
      wr(8'hBC, 8'(s << 3));
      conv(2'h0, 10'h2A5 + 10'(s), 2 << s, 0);
      res(16'(10'h2A5 + 10'(s)));
      wr(8'hE8, ctl);
    end
    wr(8'hBC, 8'h00);
    // each start mode ignores the other timer
    for (int m = 0; m < 4; m++) begin
      ctl = 8'h80 | 8'(m << 2);
      wr(8'hE8, ctl);
      t2 = (m != 3);
      t3 = (m != 1);
      @(negedge clk);
      t2 = 1'b0;
      t3 = 1'b0;
      rd(8'hE8, rv);
      chk("wrong trigger", 16'(rv), 16'(ctl));
      conv(2'(m), 10'h3C0 - 10'(m), 2, 0);
      res(16'(10'h3C0 - 10'(m)));
      pin = 1'b0;
      wr(8'hE8, ctl);
    end
    ctl = 8'h81;
    wr(8'hE8, ctl);
    conv(2'h0, 10'h2C7, 2, 0);
    res({10'h2C7, 6'h00});
    ctl = 8'hC0;
    wr(8'hE8, ctl);
    chk("low power idle", 16'(track_o), 16'h0);
    conv(2'h0, 10'h155, 2, 3);
    res(16'h0155);
    ctl = 8'hC8;
    wr(8'hE8, ctl);
    repeat (5) @(negedge clk);
    chk("pin low tracks", 16'(track_o), 16'h1);
    conv(2'h2, 10'h0AA, 2, 0);
    res(16'h00AA);
    repeat (5) @(negedge clk);
    chk("pin high holds", 16'(track_o), 16'h0);
    pin = 1'b0;
    repeat (5) @(negedge clk);
    chk("pin low again", 16'(track_o), 16'h1);
    // dropping enable mid conversion aborts it without a done flag
    ctl = 8'h80;
    wr(8'hE8, ctl);
    wr(8'hE8, 8'h90);
    rd(8'hE8, rv);
    chk("busy during conversion", 16'(rv[4]), 16'h1);
    repeat (2) @(negedge clk);
    wr(8'hE8, 8'h00);
    repeat (40) @(negedge clk);
    rd(8'hE8, rv);
    chk("abort", 16'({rv, 7'h0, done_o}), 16'h0000);
    wr(8'hE8, ctl);
    // window cases: between, strict edge, outside, edge, signed
    for (int i = 0; i < 7; i++) begin
      wr(8'hBA, {7'h00, i > 4});
      wr(8'hC7, lo_t[i][15:8]);
      wr(8'hC6, lo_t[i][7:0]);
      wr(8'hC5, up_t[i][15:8]);
      wr(8'hC4, up_t[i][7:0]);
      conv(2'h0, tg_t[i], 2, 0);
      v = (i > 4) ? tg_t[i] ^ 10'h200 : tg_t[i];
      res({{6{v[9] & (i > 4)}}, v});
      chk("window flag", 16'(win_o), 16'(wx[i]));
      wr(8'hE8, ctl);
      chk("flag cleared", 16'(win_o), 16'h0);
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire
